// >>> csi2_test_pattern_generator_tb.sv
`timescale 1ns/100ps
module csi2_test_pattern_generator_tb;
  logic CLK, RESET_N, REG_WR, RATE_400M;
  logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, PKT_DATA;
  logic PKT_VALID, PKT_SOP, PKT_EOP, PKT_SHORT;
  logic [5:0] PKT_DT;
  logic [1:0] PKT_VC;
  logic [15:0] PKT_WC;
  int fail_count = 0;
  int compares = 0;
  logic [7:0] colors [8] = '{8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc, 8'h0f, 8'h80};
  logic [7:0] rst_val [6] = '{8'h00, 8'h30, 8'h2a, 8'h01, 8'h00, 8'h00};
  logic [7:0] fix [16];
  logic [7:0] cur_cfg;
  int bar_len;

  csitpg_top dut (.CLK(CLK), .RESET_N(RESET_N), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .RATE_400M(RATE_400M),
    .PKT_VALID(PKT_VALID), .PKT_SOP(PKT_SOP), .PKT_EOP(PKT_EOP), .PKT_SHORT(PKT_SHORT),
    .PKT_DT(PKT_DT), .PKT_VC(PKT_VC), .PKT_WC(PKT_WC), .PKT_DATA(PKT_DATA));

  csitpg_sink sink (.clk(CLK), .pkt_valid(PKT_VALID), .pkt_sop(PKT_SOP), .pkt_eop(PKT_EOP),
    .pkt_short(PKT_SHORT), .pkt_dt(PKT_DT), .pkt_vc(PKT_VC), .pkt_wc(PKT_WC),
    .pkt_data(PKT_DATA));

  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask

  // An idle cycle between writes keeps each strobe a single clean pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask

  task automatic preg(input logic [7:0] ofs, input logic [7:0] d);
    wr(csitpg_pkg::WIN_OFFSET, ofs);
    wr(csitpg_pkg::WIN_DATA, d);
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    wr(csitpg_pkg::WIN_OFFSET, ofs);
    REG_ADDR = csitpg_pkg::WIN_DATA;
    repeat (2) @(negedge CLK);
    chk(REG_RDATA, exp, "register read");
  endtask

  function automatic logic [7:0] exp_byte(input int p);
    int n;
    int b;
    int blk;
    logic [7:0] v;
    n = 1 << cur_cfg[5:4];
    blk = (cur_cfg[3:0] == 4'h0) ? 16 : int'(cur_cfg[3:0]);
    b = p / bar_len;
    if (b > n - 1)
      b = n - 1;
    if (cur_cfg[7])
    begin
      v = fix[(p - b * bar_len) % blk];
      if (b % 2 == 1)
        v = ~v;
    end
    else
      v = colors[b * (8 / n)];
    return v;
  endfunction

  task automatic run_frames(input logic [7:0] cfg, input logic [7:0] di, input int lsz,
    input int bar, input int act, input int tot, input int vbp, input int vfp,
    input int lpd, input int per);
    int nl;
    cur_cfg = cfg;
    bar_len = bar;
    preg(csitpg_pkg::OFS_CFG, cfg);
    preg(csitpg_pkg::OFS_DI, di);
    preg(csitpg_pkg::OFS_LSIZE_HI, 8'(lsz >> 8));
    preg(csitpg_pkg::OFS_LSIZE_LO, 8'(lsz));
    preg(csitpg_pkg::OFS_BAR_HI, 8'(bar >> 8));
    preg(csitpg_pkg::OFS_BAR_LO, 8'(bar));
    preg(csitpg_pkg::OFS_ACT_HI, 8'h00);
    preg(csitpg_pkg::OFS_ACT_LO, 8'(act));
    preg(csitpg_pkg::OFS_TOT_HI, 8'h00);
    preg(csitpg_pkg::OFS_TOT_LO, 8'(tot));
    preg(csitpg_pkg::OFS_LPD_HI, 8'(lpd >> 8));
    preg(csitpg_pkg::OFS_LPD_LO, 8'(lpd));
    preg(csitpg_pkg::OFS_VBP, 8'(vbp));
    preg(csitpg_pkg::OFS_VFP, 8'(vfp));
    preg(csitpg_pkg::OFS_CTL, 8'h01);
    for (int i = 0; i < 8000 && sink.fs_q.size() < 2; i++)
      @(negedge CLK);
    rd(csitpg_pkg::OFS_STATUS, 8'h01);
    preg(csitpg_pkg::OFS_CTL, 8'h00);
    if (sink.fs_q.size() < 2 || sink.fe_q.size() < 1 || sink.sop_q.size() < act)
      chk(0, 1, "frame incomplete");
    else
    begin
      chk(sink.sop_q[0] - sink.fs_q[0], vbp * per, "back porch");
      chk(sink.fe_q[0] - sink.sop_q[act - 1], (vfp + 1) * per, "front porch");
      chk(sink.fs_q[1] - sink.fs_q[0], tot * per, "frame length");
      chk(sink.sop_q[1] - sink.sop_q[0], per, "line period");
      nl = 0;
      foreach (sink.sop_q[i])
        if (sink.sop_q[i] < sink.fe_q[0])
          nl++;
      chk(nl, act, "active lines");
      chk(sink.fe_q[0] - sink.fs_q[0], (vbp + act + vfp) * per, "frame order");
    end
    chk(sink.dt, di[5:0], "data type");
    chk(sink.vc, di[7:6], "channel");
    chk(sink.wc, lsz, "word count");
    chk(sink.len, lsz, "line bytes");
    for (int p = 0; p < lsz; p++)
      chk(sink.line_buf[p], exp_byte(p), "payload byte");
    repeat (2 * per) @(negedge CLK);
    sink.fs_q.delete();
    sink.fe_q.delete();
    sink.sop_q.delete();
    repeat (3 * per) @(negedge CLK);
    chk(sink.fs_q.size() + sink.sop_q.size(), 0, "stopped");
  endtask

  initial
  begin
    #400us;
    fail_count++;
    $display("unexpected at %0t: run hung", $time);
    wrap_up();
  end

  initial
  begin
    RESET_N = 1'b0;
    REG_WR = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    RATE_400M = 1'b0;
    for (int i = 0; i < 16; i++)
      fix[i] = 8'(i * 37 + 3);
    repeat (8) @(negedge CLK);
    RESET_N = 1'b1;
    wr(8'h20, 8'h30);
    wr(csitpg_pkg::WIN_PAGE, csitpg_pkg::PAGE_PGEN);
    rd(csitpg_pkg::OFS_STATUS, 8'h00);
    for (int i = 0; i < 6; i++)
      rd(8'(i + 1), rst_val[i]);
    preg(csitpg_pkg::OFS_BAR_HI, 8'h5a);
    rd(csitpg_pkg::OFS_BAR_HI, 8'h5a);
    wr(csitpg_pkg::WIN_PAGE, 8'h01);
    wr(csitpg_pkg::WIN_DATA, 8'h00);
    wr(csitpg_pkg::WIN_PAGE, csitpg_pkg::PAGE_PGEN);
    rd(csitpg_pkg::OFS_BAR_HI, 8'h5a);
    for (int i = 0; i < 16; i++)
      preg(8'(csitpg_pkg::OFS_FIXED_BASE + 8'(i)), fix[i]);
    rd(8'(csitpg_pkg::OFS_FIXED_BASE + 8'h0f), fix[15]);
    // Widths stay whole pixels of the chosen type, as software must do
    run_frames(8'h30, 8'h5e, 20, 2, 3, 8, 1, 2, 50, 25);
    for (int s = 0; s < 3; s++)
      run_frames(8'(s << 4), 8'h92, 20, 6, 2, 6, 1, 1, 50, 25);
    run_frames(8'h93, 8'h24, 20, 9, 2, 6, 2, 1, 50, 25);
    RATE_400M = 1'b1;
    run_frames(8'ha0, 8'he4, 40, 8, 2, 5, 1, 1, 100, 100);
    wrap_up();
  end
endmodule // csi2_test_pattern_generator_tb

// >>> csitpg_blockmem.sv
`timescale 1ns/100ps
module csitpg_blockmem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8,
  parameter int AW = $clog2(DEPTH)
) (
  input logic clk,
  input logic reset_n,
  input logic we,
  input logic [AW-1:0] waddr,
  input logic [WIDTH-1:0] wdata,
  input logic [AW-1:0] raddr_a,
  output logic [WIDTH-1:0] rdata_a,
  input logic [AW-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_b
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else if (we)
      mem_q[waddr] <= wdata;
  end

  // Port a feeds the stream, port b the register readback
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_a <= '0;
      rdata_b <= '0;
    end
    else
    begin
      rdata_a <= mem_q[raddr_a];
      rdata_b <= mem_q[raddr_b];
    end
  end
endmodule // csitpg_blockmem

// >>> csitpg_cfg_if.sv
`timescale 1ns/100ps
interface csitpg_cfg_if;
  logic wr;
  logic [7:0] ofs;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport win (output wr, output ofs, output wdata, input rdata);
  modport gen (input wr, input ofs, input wdata, output rdata);
endinterface

// >>> csitpg_pkg.sv
package csitpg_pkg;
  // Indirect window addresses on the control bus
  localparam logic [7:0] WIN_PAGE = 8'hb0;
  localparam logic [7:0] WIN_OFFSET = 8'hb1;
  localparam logic [7:0] WIN_DATA = 8'hb2;
  localparam logic [7:0] PAGE_PGEN = 8'h00;

  // Generator page offsets
  localparam logic [7:0] OFS_CTL = 8'h01;
  localparam logic [7:0] OFS_CFG = 8'h02;
  localparam logic [7:0] OFS_DI = 8'h03;
  localparam logic [7:0] OFS_LSIZE_HI = 8'h04;
  localparam logic [7:0] OFS_LSIZE_LO = 8'h05;
  localparam logic [7:0] OFS_BAR_HI = 8'h06;
  localparam logic [7:0] OFS_BAR_LO = 8'h07;
  localparam logic [7:0] OFS_ACT_HI = 8'h08;
  localparam logic [7:0] OFS_ACT_LO = 8'h09;
  localparam logic [7:0] OFS_TOT_HI = 8'h0a;
  localparam logic [7:0] OFS_TOT_LO = 8'h0b;
  localparam logic [7:0] OFS_LPD_HI = 8'h0c;
  localparam logic [7:0] OFS_LPD_LO = 8'h0d;
  localparam logic [7:0] OFS_VBP = 8'h0e;
  localparam logic [7:0] OFS_VFP = 8'h0f;
  localparam logic [7:0] OFS_FIXED_BASE = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // Field positions
  localparam int CTL_EN_BIT = 0;
  localparam int CFG_FIXED_BIT = 7;
  localparam int CFG_BARS_LSB = 4;
  localparam int CFG_BLK_LSB = 0;
  localparam int DI_VC_LSB = 6;

  // Reset values
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_CFG = 8'h30;
  localparam logic [7:0] RST_DI = 8'h2a;
  localparam logic [15:0] RST_LSIZE = 16'h0100;
  localparam logic [15:0] RST_BAR = 16'h0020;
  localparam logic [15:0] RST_ACT = 16'h0010;
  localparam logic [15:0] RST_TOT = 16'h0018;
  localparam logic [15:0] RST_LPD = 16'h0064;
  localparam logic [7:0] RST_VBP = 8'h02;
  localparam logic [7:0] RST_VFP = 8'h02;

  // Line period step versus the 20 ns clock
  localparam int CLK_PERIOD_NS = 20;
  localparam int STEP_NS = 10;
  localparam int STEP_400_NS = 20;
  localparam logic [1:0] UNITS_PER_CLK = 2'(CLK_PERIOD_NS / STEP_NS);
  localparam logic [1:0] UNITS_PER_CLK_400 = 2'(CLK_PERIOD_NS / STEP_400_NS);

  // Short packet data types
  localparam logic [5:0] DT_FS = 6'h00;
  localparam logic [5:0] DT_FE = 6'h01;

  localparam int FIXED_DEPTH = 16;

  localparam logic [7:0] BAR_COLOR [8] = '{8'haa, 8'h33, 8'hf0, 8'h7f,
                                           8'h55, 8'hcc, 8'h0f, 8'h80};

  function automatic logic [2:0] bar_count_m1(input logic [1:0] sel);
    bar_count_m1 = 3'((4'h1 << sel) - 4'h1);
  endfunction
endpackage

// >>> csitpg_sink.sv
`timescale 1ns/100ps
// Passive model of the transmitter packet input: it takes every cycle.
module csitpg_sink (
  input logic clk,
  input logic pkt_valid,
  input logic pkt_sop,
  input logic pkt_eop,
  input logic pkt_short,
  input logic [5:0] pkt_dt,
  input logic [1:0] pkt_vc,
  input logic [15:0] pkt_wc,
  input logic [7:0] pkt_data
);
  int cyc = 0;
  int fs_q[$];
  int fe_q[$];
  int sop_q[$];
  logic [7:0] line_buf [128];
  int idx = 0;
  int len = 0;
  logic [5:0] dt;
  logic [1:0] vc;
  logic [15:0] wc;

  // Timestamps in clock cycles so the bench can check line spacing
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (pkt_valid === 1'b1 && pkt_short === 1'b1)
    begin
      if (pkt_dt === 6'h00)
        fs_q.push_back(cyc);
      else if (pkt_dt === 6'h01)
        fe_q.push_back(cyc);
    end
    else if (pkt_valid === 1'b1)
    begin
      if (pkt_sop === 1'b1)
      begin
        idx = 0;
        dt = pkt_dt;
        vc = pkt_vc;
        wc = pkt_wc;
        sop_q.push_back(cyc);
      end
      if (idx < 128)
        line_buf[idx] = pkt_data;
      idx = idx + 1;
      if (pkt_eop === 1'b1)
        len = idx;
    end
  end
endmodule // csitpg_sink

// >>> csitpg_top.sv
`timescale 1ns/100ps
module csitpg_top (
  input logic CLK,
  input logic RESET_N,
  input logic REG_WR,
  input logic [7:0] REG_ADDR,
  input logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input logic RATE_400M,
  output logic PKT_VALID,
  output logic PKT_SOP,
  output logic PKT_EOP,
  output logic PKT_SHORT,
  output logic [5:0] PKT_DT,
  output logic [1:0] PKT_VC,
  output logic [15:0] PKT_WC,
  output logic [7:0] PKT_DATA
);
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_FSTART, ST_LINE, ST_FEND} csitpg_state_t;

  csitpg_cfg_if cfg_bus ();

  logic [7:0] ctl_q;
  logic [7:0] cfg_q;
  logic [7:0] di_q;
  logic [15:0] lsize_q;
  logic [15:0] bar_q;
  logic [15:0] act_q;
  logic [15:0] tot_q;
  logic [15:0] lpd_q;
  logic [7:0] vbp_q;
  logic [7:0] vfp_q;
  logic [7:0] fix_byte;
  logic [7:0] fix_rd;
  logic mem_we;

  csitpg_state_t state_q;
  logic [15:0] lidx_q;
  logic lact_q;
  logic pend_q;
  logic [15:0] acc_q;
  logic [15:0] bc_q;
  logic [15:0] bb_q;
  logic [2:0] bi_q;
  logic [3:0] k_q;
  logic [3:0] k_d;

  csitpg_window u_window (
    .clk(CLK),
    .reset_n(RESET_N),
    .reg_wr(REG_WR),
    .reg_addr(REG_ADDR),
    .reg_wdata(REG_WDATA),
    .reg_rdata(REG_RDATA),
    .bus(cfg_bus.win)
  );

  assign mem_we = cfg_bus.wr && cfg_bus.ofs[7:4] == csitpg_pkg::OFS_FIXED_BASE[7:4];

  csitpg_blockmem #(
    .DEPTH(csitpg_pkg::FIXED_DEPTH),
    .WIDTH(8)
  ) u_mem (
    .clk(CLK),
    .reset_n(RESET_N),
    .we(mem_we),
    .waddr(cfg_bus.ofs[3:0]),
    .wdata(cfg_bus.wdata),
    .raddr_a(k_d),
    .rdata_a(fix_byte),
    .raddr_b(cfg_bus.ofs[3:0]),
    .rdata_b(fix_rd)
  );

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctl_q <= csitpg_pkg::RST_CTL;
      cfg_q <= csitpg_pkg::RST_CFG;
      di_q <= csitpg_pkg::RST_DI;
      lsize_q <= csitpg_pkg::RST_LSIZE;
      bar_q <= csitpg_pkg::RST_BAR;
      act_q <= csitpg_pkg::RST_ACT;
      tot_q <= csitpg_pkg::RST_TOT;
      lpd_q <= csitpg_pkg::RST_LPD;
      vbp_q <= csitpg_pkg::RST_VBP;
      vfp_q <= csitpg_pkg::RST_VFP;
    end
    else if (cfg_bus.wr)
    begin
      case (cfg_bus.ofs)
        csitpg_pkg::OFS_CTL: ctl_q <= cfg_bus.wdata;
        csitpg_pkg::OFS_CFG: cfg_q <= cfg_bus.wdata;
        csitpg_pkg::OFS_DI: di_q <= cfg_bus.wdata;
        csitpg_pkg::OFS_LSIZE_HI: lsize_q[15:8] <= cfg_bus.wdata;
        csitpg_pkg::OFS_LSIZE_LO: lsize_q[7:0] <= cfg_bus.wdata;
        csitpg_pkg::OFS_BAR_HI: bar_q[15:8] <= cfg_bus.wdata;
        csitpg_pkg::OFS_BAR_LO: bar_q[7:0] <= cfg_bus.wdata;
        csitpg_pkg::OFS_ACT_HI: act_q[15:8] <= cfg_bus.wdata;
        csitpg_pkg::OFS_ACT_LO: act_q[7:0] <= cfg_bus.wdata;
        csitpg_pkg::OFS_TOT_HI: tot_q[15:8] <= cfg_bus.wdata;
        csitpg_pkg::OFS_TOT_LO: tot_q[7:0] <= cfg_bus.wdata;
        csitpg_pkg::OFS_LPD_HI: lpd_q[15:8] <= cfg_bus.wdata;
        csitpg_pkg::OFS_LPD_LO: lpd_q[7:0] <= cfg_bus.wdata;
        csitpg_pkg::OFS_VBP: vbp_q <= cfg_bus.wdata;
        csitpg_pkg::OFS_VFP: vfp_q <= cfg_bus.wdata;
        default: ;
      endcase
    end
  end

  always_comb
  begin
    case (cfg_bus.ofs)
      csitpg_pkg::OFS_CTL: cfg_bus.rdata = ctl_q;
      csitpg_pkg::OFS_CFG: cfg_bus.rdata = cfg_q;
      csitpg_pkg::OFS_DI: cfg_bus.rdata = di_q;
      csitpg_pkg::OFS_LSIZE_HI: cfg_bus.rdata = lsize_q[15:8];
      csitpg_pkg::OFS_LSIZE_LO: cfg_bus.rdata = lsize_q[7:0];
      csitpg_pkg::OFS_BAR_HI: cfg_bus.rdata = bar_q[15:8];
      csitpg_pkg::OFS_BAR_LO: cfg_bus.rdata = bar_q[7:0];
      csitpg_pkg::OFS_ACT_HI: cfg_bus.rdata = act_q[15:8];
      csitpg_pkg::OFS_ACT_LO: cfg_bus.rdata = act_q[7:0];
      csitpg_pkg::OFS_TOT_HI: cfg_bus.rdata = tot_q[15:8];
      csitpg_pkg::OFS_TOT_LO: cfg_bus.rdata = tot_q[7:0];
      csitpg_pkg::OFS_LPD_HI: cfg_bus.rdata = lpd_q[15:8];
      csitpg_pkg::OFS_LPD_LO: cfg_bus.rdata = lpd_q[7:0];
      csitpg_pkg::OFS_VBP: cfg_bus.rdata = vbp_q;
      csitpg_pkg::OFS_VFP: cfg_bus.rdata = vfp_q;
      csitpg_pkg::OFS_STATUS: cfg_bus.rdata = {6'h00, state_q == ST_LINE, state_q != ST_IDLE};
      default: cfg_bus.rdata = 8'h00;
    endcase
    if (cfg_bus.ofs[7:4] == csitpg_pkg::OFS_FIXED_BASE[7:4])
      cfg_bus.rdata = fix_rd;
  end

  logic en;
  logic fixed;
  logic [1:0] bars_sel;
  logic [2:0] nbars_m1;
  logic [3:0] blk_m1;
  logic [2:0] bar_idx;
  assign en = ctl_q[csitpg_pkg::CTL_EN_BIT];
  assign fixed = cfg_q[csitpg_pkg::CFG_FIXED_BIT];
  assign bars_sel = cfg_q[csitpg_pkg::CFG_BARS_LSB +: 2];
  assign nbars_m1 = csitpg_pkg::bar_count_m1(bars_sel);
  // A block size field of zero wraps to sixteen bytes
  assign blk_m1 = cfg_q[csitpg_pkg::CFG_BLK_LSB +: 4] - 4'h1;
  // Fewer bars pick evenly spaced colours of the eight
  assign bar_idx = 3'(bi_q << (3'h3 - {1'b0, bars_sel}));

  // Line period accumulates 10 ns units, two per 20 ns clock; with RATE_400M the unit is 20 ns, one per clock
  logic [1:0] inc;
  logic [16:0] acc_sum;
  logic tick;
  logic armed_q;
  assign inc = RATE_400M ? csitpg_pkg::UNITS_PER_CLK_400 : csitpg_pkg::UNITS_PER_CLK;
  assign acc_sum = {1'b0, acc_q} + {15'h0000, inc};
  assign tick = armed_q && state_q != ST_IDLE && acc_sum >= {1'b0, lpd_q};

  // Line zero on enable stands in for a tick, so counting starts one cycle later
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      armed_q <= 1'b0;
      acc_q <= 16'h0000;
    end
    else
    begin
      armed_q <= state_q != ST_IDLE;
      if (!armed_q || state_q == ST_IDLE || tick)
        acc_q <= 16'h0000;
      else
        acc_q <= acc_sum[15:0];
    end
  end

  logic [15:0] act_start;
  logic [15:0] act_end;
  logic [15:0] fe_line;
  logic line_act;
  logic go;
  assign act_start = {8'h00, vbp_q};
  assign act_end = 16'(act_start + act_q);
  assign fe_line = 16'(act_end + {8'h00, vfp_q});
  assign line_act = lidx_q >= act_start && lidx_q < act_end;
  assign go = tick || pend_q;

  // A period that ends mid-line is remembered so no line slot is lost
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_q <= ST_IDLE;
      lidx_q <= 16'h0000;
      lact_q <= 1'b0;
      pend_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (en)
          begin
            state_q <= ST_WAIT;
            lidx_q <= 16'h0000;
            pend_q <= 1'b1;
          end
        end
        ST_WAIT:
        begin
          if (!en)
            state_q <= ST_IDLE;
          else if (go)
          begin
            // A fresh tick in the same cycle stays pending
            pend_q <= pend_q && tick;
            lact_q <= line_act;
            lidx_q <= lidx_q >= 16'(tot_q - 16'h0001) ? 16'h0000 : 16'(lidx_q + 16'h0001);
            if (lidx_q == 16'h0000)
              state_q <= ST_FSTART;
            else if (lidx_q == fe_line)
              state_q <= ST_FEND;
            else if (line_act)
              state_q <= ST_LINE;
          end
        end
        ST_FSTART:
        begin
          pend_q <= pend_q || tick;
          state_q <= lact_q ? ST_LINE : ST_WAIT;
        end
        ST_LINE:
        begin
          pend_q <= pend_q || tick;
          if (bc_q == 16'(lsize_q - 16'h0001))
            state_q <= ST_WAIT;
        end
        ST_FEND:
        begin
          pend_q <= pend_q || tick;
          state_q <= ST_WAIT;
        end
      endcase
    end
  end

  logic last;
  logic bar_end;
  assign last = bc_q == 16'(lsize_q - 16'h0001);
  assign bar_end = bb_q == 16'(bar_q - 16'h0001) && bi_q != nbars_m1;

  always_comb
  begin
    k_d = 4'h0;
    if (state_q == ST_LINE && !last && !bar_end)
      k_d = k_q == blk_m1 ? 4'h0 : 4'(k_q + 4'h1);
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      bc_q <= 16'h0000;
      bb_q <= 16'h0000;
      bi_q <= 3'h0;
      k_q <= 4'h0;
    end
    else
    begin
      k_q <= k_d;
      if (state_q == ST_LINE && !last)
      begin
        bc_q <= 16'(bc_q + 16'h0001);
        bb_q <= bar_end ? 16'h0000 : 16'(bb_q + 16'h0001);
        bi_q <= bar_end ? 3'(bi_q + 3'h1) : bi_q;
      end
      else
      begin
        bc_q <= 16'h0000;
        bb_q <= 16'h0000;
        bi_q <= 3'h0;
      end
    end
  end

  // Header fields travel beside the first byte; the transmitter adds ECC and CRC
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      PKT_VALID <= 1'b0;
      PKT_SOP <= 1'b0;
      PKT_EOP <= 1'b0;
      PKT_SHORT <= 1'b0;
      PKT_DT <= 6'h00;
      PKT_VC <= 2'h0;
      PKT_WC <= 16'h0000;
      PKT_DATA <= 8'h00;
    end
    else
    begin
      PKT_VALID <= state_q == ST_FSTART || state_q == ST_FEND || state_q == ST_LINE;
      PKT_SHORT <= state_q == ST_FSTART || state_q == ST_FEND;
      PKT_SOP <= state_q != ST_LINE ? state_q != ST_IDLE && state_q != ST_WAIT : bc_q == 16'h0;
      PKT_EOP <= state_q != ST_LINE ? state_q != ST_IDLE && state_q != ST_WAIT : last;
      PKT_VC <= di_q[csitpg_pkg::DI_VC_LSB +: 2];
      PKT_WC <= state_q == ST_LINE ? lsize_q : 16'h0000;
      if (state_q == ST_FSTART)
        PKT_DT <= csitpg_pkg::DT_FS;
      else if (state_q == ST_FEND)
        PKT_DT <= csitpg_pkg::DT_FE;
      else
        PKT_DT <= di_q[5:0];
      if (state_q == ST_LINE)
        PKT_DATA <= fixed ? fix_byte ^ {8{bi_q[0]}} : csitpg_pkg::BAR_COLOR[bar_idx];
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  a_bar_first: assert property (PKT_SOP && !PKT_SHORT && !$past(fixed) |-> PKT_DATA == 8'haa)
    else $error("first colour bar byte wrong");
  a_bar_last: assert property (PKT_VALID && !PKT_SHORT && !$past(fixed) && $past(bars_sel) == 2'h3
    && $past(bi_q) == 3'h7 |-> PKT_DATA == 8'h80)
    else $error("eighth colour bar byte wrong");
  a_bar_step: assert property (state_q == ST_LINE && !last && bar_end
    |=> bi_q == 3'($past(bi_q) + 3'h1) && bb_q == 16'h0000)
    else $error("bar did not advance after its length");
  a_bar_count: assert property (state_q == ST_LINE |-> bi_q <= nbars_m1)
    else $error("bar index beyond selected count");
  a_line_bytes: assert property (PKT_EOP && !PKT_SHORT
    |-> $past(bc_q) == 16'($past(lsize_q) - 16'h0001))
    else $error("line ended at wrong byte count");
  a_header_di: assert property (PKT_SOP && !PKT_SHORT |-> {PKT_VC, PKT_DT} == $past(di_q))
    else $error("long packet header mismatch");
  a_fend_line: assert property (state_q == ST_FEND |-> $past(lidx_q) == $past(fe_line))
    else $error("frame end on wrong line");
  a_fstart_line: assert property (state_q == ST_FSTART |-> $past(lidx_q) == 16'h0000)
    else $error("frame start not on line zero");
  a_period_gap: assert property (tick && !RATE_400M && lpd_q >= 16'h0006
    |=> acc_q == 16'h0000 ##0 !tick ##1 !tick)
    else $error("line period tick too early");
  a_fixed_inv: assert property (PKT_VALID && !PKT_SHORT && $past(fixed) && $past(bi_q[0])
    |-> PKT_DATA == ~$past(fix_byte))
    else $error("odd bar not inverted in fixed mode");
  a_block_wrap: assert property (state_q == ST_LINE && !last && !bar_end && k_q == blk_m1
    |=> k_q == 4'h0)
    else $error("block index did not wrap");
  a_ctl_write: assert property (cfg_bus.wr && cfg_bus.ofs == csitpg_pkg::OFS_CTL
    |=> ctl_q == $past(cfg_bus.wdata))
    else $error("window write to control lost");
endmodule // csitpg_top

// >>> csitpg_window.sv
`timescale 1ns/100ps
module csitpg_window (
  input logic clk,
  input logic reset_n,
  input logic reg_wr,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  csitpg_cfg_if.win bus
);
  logic [7:0] page_q;
  logic [7:0] ofs_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      page_q <= 8'h00;
      ofs_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == csitpg_pkg::WIN_PAGE)
        page_q <= reg_wdata;
      if (reg_addr == csitpg_pkg::WIN_OFFSET)
        ofs_q <= reg_wdata;
    end
  end

  // Data writes reach the generator only while its page is selected
  assign bus.wr = reg_wr && reg_addr == csitpg_pkg::WIN_DATA
                  && page_q == csitpg_pkg::PAGE_PGEN;
  assign bus.ofs = ofs_q;
  assign bus.wdata = reg_wdata;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_addr == csitpg_pkg::WIN_PAGE)
      reg_rdata <= page_q;
    else if (reg_addr == csitpg_pkg::WIN_OFFSET)
      reg_rdata <= ofs_q;
    else if (reg_addr == csitpg_pkg::WIN_DATA && page_q == csitpg_pkg::PAGE_PGEN)
      reg_rdata <= bus.rdata;
    else
      reg_rdata <= 8'h00;
  end
endmodule // csitpg_window
